// file: include/spm_pkg.sv
// spm_pkg: constants and types for the set point switch and menu control block
// assumes a 10 MHz system clock; all values in process counts, signed except the deadband, which is unsigned
package spm_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_S = 120;           // inactivity timeout, seconds
  localparam int PRESCALE_DEF = 10_000_000; // ticks per second at CLK_HZ
  localparam int TIMEOUT_TICKS = TIMEOUT_S; // prescaled seconds counted
  localparam int DEBOUNCE_NS = 10_000_000;  // 10 ms debounce
  localparam int DEBOUNCE_CYC = DEBOUNCE_NS / (1_000_000_000 / CLK_HZ);
  localparam int VAL_W = 16;
  localparam logic [15:0] PASSWORD_RST = 16'h0000; // four bcd digits
  localparam logic [2:0] UNIT_RST = 3'h0;           // psi or deg F
  localparam int UNIT_COUNT = 4;
  typedef enum logic [2:0] {
    SPM_OPEN_RISE, SPM_OPEN_FALL, SPM_OPEN_WIN,
    SPM_CLOSE_RISE, SPM_CLOSE_FALL, SPM_CLOSE_WIN
  } spm_mode_type;
  typedef enum {
    SPM_ONLINE, SPM_ARMED, SPM_PASSWORD, SPM_PASS_OK, SPM_LATCH_PROMPT,
    SPM_LATCH_DONE, SPM_EXTREMES, SPM_UNITS, SPM_UNIT_SEL, SPM_SWITCH_MODE,
    SPM_COMMIT, SPM_COMMIT_SEL
  } spm_state_type;
  // display message codes for the display renderer
  localparam logic [3:0] MSG_PROCESS = 4'h0;
  localparam logic [3:0] MSG_ERROR = 4'h1;
  localparam logic [3:0] MSG_PASSWORD = 4'h2;
  localparam logic [3:0] MSG_OK = 4'h3;
  localparam logic [3:0] MSG_LATCH_PROMPT = 4'h4;
  localparam logic [3:0] MSG_LATCH_DONE = 4'h5;
  localparam logic [3:0] MSG_EXTREMES = 4'h6;
  localparam logic [3:0] MSG_UNITS = 4'h7;
  localparam logic [3:0] MSG_UNIT_SEL = 4'h8;
  localparam logic [3:0] MSG_MODE = 4'h9;
  localparam logic [3:0] MSG_COMMIT = 4'hA;
  localparam logic [3:0] MSG_COMMIT_NO = 4'hB;
  localparam logic [3:0] MSG_COMMIT_YES = 4'hC;
  localparam logic [3:0] MSG_DEADBAND_BAD = 4'hD;
endpackage

// file: include/spm_key_if.sv
// spm_key_if: debounced key events passed from the key filter to the menu
// assumes one clock domain; events are one-cycle pulses
`timescale 1ns/10ps
interface spm_key_if;
  logic left_ev;
  logic right_ev;
  logic both_ev;
  modport src (output left_ev, output right_ev, output both_ev);
  modport dst (input left_ev, input right_ev, input both_ev);
endinterface

// file: rtl/spm_keys.sv
// spm_keys: synchronises, debounces and classifies the two operator keys
// assumes raw key pins are active high and asynchronous to the clock
`timescale 1ns/10ps
module spm_keys
  import spm_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // raw keys
  input wire logic i_key_left,
  input wire logic i_key_right,
  // events
  spm_key_if.src keys
);
  logic [1:0] sync1, sync2, stable, next_stable;
  logic [1:0] seen, next_seen;
  logic [$clog2(DEB_CYC+1)-1:0] cnt, next_cnt;
  logic next_l, next_r, next_b;

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
    end else begin
      sync1 <= {i_key_left, i_key_right};
      sync2 <= sync1;
    end
  end

  // debounce and collect keys pressed during one press group
  always_comb begin
    next_stable = stable;
    next_cnt = cnt;
    next_seen = seen;
    next_l = 1'b0;
    next_r = 1'b0;
    next_b = 1'b0;
    if (sync2 == stable) begin
      next_cnt = '0;
    end else if (cnt == ($clog2(DEB_CYC+1))'(DEB_CYC - 1)) begin
      next_cnt = '0;
      next_stable = sync2;
    end else begin
      next_cnt = cnt + 1'b1;
    end
    next_seen = seen | next_stable;
    // event on release of all keys: both counts as one distinct event
    if (stable != 2'h0 && next_stable == 2'h0) begin
      next_seen = 2'h0;
      next_b = (seen | stable) == 2'h3;
      next_l = (seen | stable) == 2'h2;
      next_r = (seen | stable) == 2'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      stable <= 2'h0;
      cnt <= '0;
      seen <= 2'h0;
      keys.left_ev <= 1'b0;
      keys.right_ev <= 1'b0;
      keys.both_ev <= 1'b0;
    end else begin
      stable <= next_stable;
      cnt <= next_cnt;
      seen <= next_seen;
      keys.left_ev <= next_l;
      keys.right_ev <= next_r;
      keys.both_ev <= next_b;
    end
  end

  AST_ONE_EVENT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $onehot0({keys.left_ev, keys.right_ev, keys.both_ev}))
    else $error("key events overlap");
endmodule // spm_keys

// file: rtl/spm_top.sv
// spm_top: set point switch, health output and two-key programming menu
// assumes process value and fault flags come from logic on the same clock
//
// Operation
// - show error on external fault while running
// - stop activity indicator on controller fault
// - programming: offline, fail-safe outputs, ignore sensor
// - switch fail-safe level follows configured mode
// - both keys then right key enters programming
// - four-digit password, left increments, right advances
// - OK, then extremes or latch-release prompt
// - two idle minutes: discard, reload, go online
// - main menu steps forward only, circular
// - both keys jump to commit at escape items
// - left key steps forward until commit prompt
// - commit defaults NO; left toggles; both saves
// - both with NO discards and goes online
// - unit default zero; left cycles, right selects
// - unit change zeroes extremes, requests recompute
// - six switch modes: open/close rise/fall/window
// - rising: trip at set point, reset below
// - falling: trip at set point, reset above
// - window: trip outside high/low limits
// - health output off in fault or reset
// - latch holds trip until menu release
// - zero deadband rejected at commit
// - fault turns health output off
// - both keys at latch prompt release latch
`timescale 1ns/10ps
module spm_top
  import spm_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_DEF,
  parameter int TIMEOUT = TIMEOUT_TICKS,
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int W = VAL_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // keys
  input wire logic i_key_left,
  input wire logic i_key_right,
  // process and faults
  input wire logic signed [W-1:0] i_process_value,
  input wire logic i_fault_external,
  input wire logic i_fault_controller,
  // working parameters written by the editing front end
  input wire logic [2:0] i_edit_mode,
  input wire logic signed [W-1:0] i_edit_setpoint_hi,
  input wire logic signed [W-1:0] i_edit_setpoint_lo,
  input wire logic [W-1:0] i_edit_deadband,
  input wire logic i_edit_latch_en,
  // outputs to control system
  output logic o_switch_closed,
  output logic o_health_ok_output,
  // status
  output logic o_online,
  output logic o_activity_run,
  output logic [3:0] o_message,
  output logic [3:0] o_digit_index,
  output logic [3:0] o_digit_value,
  output logic [2:0] o_unit,
  output logic o_unit_changed,
  output logic o_extremes_clear_cmd,
  output logic o_latched,
  output logic o_tripped
);
  spm_key_if key_bus ();

  spm_keys #(.DEB_CYC(DEB_CYC)) u_keys (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_key_left(i_key_left),
    .i_key_right(i_key_right),
    .keys(key_bus)
  );

  wire any_ev = key_bus.left_ev | key_bus.right_ev | key_bus.both_ev;

  spm_state_type state, next_state;
  logic [15:0] pw_entry, next_pw_entry;
  logic [1:0] digit, next_digit;
  logic yes_sel, next_yes_sel;
  logic [2:0] unit, next_unit, edit_unit, next_edit_unit;
  logic [2:0] mode, next_mode;
  logic signed [W-1:0] sp_hi, next_sp_hi, sp_lo, next_sp_lo;
  logic [W-1:0] db, next_db;
  logic latch_en, next_latch_en;
  logic clr_req, next_clr_req;
  logic tripped, next_tripped, latched, next_latched;
  logic unit_pulse, next_unit_pulse, clr_pulse, next_clr_pulse;
  logic db_bad, next_db_bad;
  logic [$clog2(PRESCALE+1)-1:0] pre, next_pre;
  logic [$clog2(TIMEOUT+1)-1:0] secs, next_secs;
  logic timeout;

  // prescaled inactivity timer, restarted by every key event
  always_comb begin
    next_pre = pre;
    next_secs = secs;
    timeout = (secs == ($clog2(TIMEOUT+1))'(TIMEOUT));
    if (state == SPM_ONLINE || any_ev) begin
      next_pre = '0;
      next_secs = '0;
    end else if (pre == ($clog2(PRESCALE+1))'(PRESCALE - 1)) begin
      next_pre = '0;
      if (!timeout) next_secs = secs + 1'b1;
    end else begin
      next_pre = pre + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pre <= '0;
      secs <= '0;
    end else begin
      pre <= next_pre;
      secs <= next_secs;
    end
  end

  // menu state machine and stored parameters
  always_comb begin
    next_state = state;
    next_pw_entry = pw_entry;
    next_digit = digit;
    next_yes_sel = yes_sel;
    next_unit = unit;
    next_edit_unit = edit_unit;
    next_mode = mode;
    next_sp_hi = sp_hi;
    next_sp_lo = sp_lo;
    next_db = db;
    next_latch_en = latch_en;
    next_clr_req = clr_req;
    next_latched = latched;
    next_unit_pulse = 1'b0;
    next_clr_pulse = 1'b0;
    next_db_bad = db_bad;
    if (state != SPM_ONLINE && state != SPM_ARMED && timeout) begin
      next_state = SPM_ONLINE;
      next_edit_unit = unit;
      next_clr_req = 1'b0;
    end else begin
      unique case (state)
        SPM_ONLINE: if (key_bus.both_ev) next_state = SPM_ARMED;
        SPM_ARMED: begin
          if (key_bus.right_ev) begin
            next_state = SPM_PASSWORD;
            next_pw_entry = 16'h0000;
            next_digit = 2'h0;
            next_edit_unit = unit;
            next_db_bad = 1'b0;
          end else if (any_ev) begin
            next_state = SPM_ONLINE;
          end
        end
        SPM_PASSWORD: begin
          if (key_bus.left_ev) begin
            // increment blinking bcd digit
            next_pw_entry[digit*4 +: 4] = (pw_entry[digit*4 +: 4] == 4'h9) ? 4'h0
              : pw_entry[digit*4 +: 4] + 4'h1;
          end else if (key_bus.right_ev) begin
            next_digit = digit + 2'h1;
            if (digit == 2'h3) begin
              next_state = (pw_entry == PASSWORD_RST) ? SPM_PASS_OK : SPM_ONLINE;
            end
          end
        end
        SPM_PASS_OK: if (key_bus.right_ev) begin
          next_state = latched ? SPM_LATCH_PROMPT : SPM_EXTREMES;
        end
        SPM_LATCH_PROMPT: begin
          if (key_bus.both_ev) begin
            next_latched = 1'b0;
            next_state = SPM_LATCH_DONE;
          end else if (key_bus.right_ev) begin
            next_state = SPM_ONLINE;
          end else if (key_bus.left_ev) begin
            next_state = SPM_EXTREMES;
          end
        end
        SPM_LATCH_DONE: begin
          if (key_bus.right_ev) next_state = SPM_ONLINE;
          else if (key_bus.left_ev) next_state = SPM_EXTREMES;
        end
        SPM_EXTREMES: begin
          if (key_bus.right_ev) next_clr_req = 1'b1;
          if (key_bus.left_ev) next_state = SPM_UNITS;
          if (key_bus.both_ev) next_state = SPM_COMMIT;
        end
        SPM_UNITS: begin
          if (key_bus.right_ev) next_state = SPM_UNIT_SEL;
          if (key_bus.left_ev) next_state = SPM_SWITCH_MODE;
          if (key_bus.both_ev) next_state = SPM_COMMIT;
        end
        SPM_UNIT_SEL: begin
          if (key_bus.left_ev) begin
            next_edit_unit = (edit_unit == 3'(UNIT_COUNT - 1)) ? 3'h0
              : edit_unit + 3'h1;
          end
          if (key_bus.right_ev) next_state = SPM_UNITS;
        end
        SPM_SWITCH_MODE: begin
          // mode editing not escape-permitted; left moves on
          if (key_bus.left_ev) next_state = SPM_COMMIT;
        end
        SPM_COMMIT: begin
          if (key_bus.right_ev) begin
            next_state = SPM_COMMIT_SEL;
            next_yes_sel = 1'b0;
          end
          if (key_bus.left_ev) next_state = SPM_EXTREMES;
        end
        SPM_COMMIT_SEL: begin
          if (key_bus.left_ev) next_yes_sel = ~yes_sel;
          if (key_bus.both_ev) begin
            if (yes_sel && i_edit_deadband == '0) begin
              next_db_bad = 1'b1;
            end else begin
              next_state = SPM_ONLINE;
              next_clr_req = 1'b0;
              if (yes_sel) begin
                next_mode = (i_edit_mode > 3'h5) ? mode : i_edit_mode;
                next_sp_hi = i_edit_setpoint_hi;
                next_sp_lo = i_edit_setpoint_lo;
                next_db = i_edit_deadband;
                next_latch_en = i_edit_latch_en;
                next_clr_pulse = clr_req;
                if (edit_unit != unit) begin
                  next_unit = edit_unit;
                  next_unit_pulse = 1'b1;
                  next_clr_pulse = 1'b1;
                end
              end else begin
                next_edit_unit = unit;
              end
            end
          end
        end
      endcase
    end
    if (!latch_en) next_latched = 1'b0;
    else if (next_tripped && state == SPM_ONLINE) next_latched = 1'b1;
  end

  // switch decision: trip and reset thresholds, with hysteresis in rise and fall modes only
  logic signed [W:0] pv, hi, lo, dbx;
  always_comb begin
    pv = {i_process_value[W-1], i_process_value};
    hi = {sp_hi[W-1], sp_hi};
    lo = {sp_lo[W-1], sp_lo};
    dbx = {1'b0, db};
    next_tripped = tripped;
    if (state != SPM_ONLINE) begin
      next_tripped = tripped;
    end else if (latched) begin
      next_tripped = 1'b1;
    end else begin
      unique case (mode)
        SPM_OPEN_RISE, SPM_CLOSE_RISE: begin
          if (pv >= hi) next_tripped = 1'b1;
          else if (pv <= hi - dbx) next_tripped = 1'b0;
        end
        SPM_OPEN_FALL, SPM_CLOSE_FALL: begin
          if (pv <= hi) next_tripped = 1'b1;
          else if (pv >= hi + dbx) next_tripped = 1'b0;
        end
        SPM_OPEN_WIN, SPM_CLOSE_WIN: next_tripped = (pv > hi) || (pv < lo);
        default: next_tripped = tripped;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= SPM_ONLINE;
      pw_entry <= 16'h0000;
      digit <= 2'h0;
      yes_sel <= 1'b0;
      unit <= UNIT_RST;
      edit_unit <= UNIT_RST;
      mode <= SPM_OPEN_RISE;
      sp_hi <= '0;
      sp_lo <= '0;
      db <= W'(1);
      latch_en <= 1'b0;
      clr_req <= 1'b0;
      tripped <= 1'b0;
      latched <= 1'b0;
      unit_pulse <= 1'b0;
      clr_pulse <= 1'b0;
      db_bad <= 1'b0;
    end else begin
      state <= next_state;
      pw_entry <= next_pw_entry;
      digit <= next_digit;
      yes_sel <= next_yes_sel;
      unit <= next_unit;
      edit_unit <= next_edit_unit;
      mode <= next_mode;
      sp_hi <= next_sp_hi;
      sp_lo <= next_sp_lo;
      db <= next_db;
      latch_en <= next_latch_en;
      clr_req <= next_clr_req;
      tripped <= next_tripped;
      latched <= next_latched;
      unit_pulse <= next_unit_pulse;
      clr_pulse <= next_clr_pulse;
      db_bad <= next_db_bad;
    end
  end

  // output registers
  wire open_mode = (mode == SPM_OPEN_RISE) || (mode == SPM_OPEN_FALL) || (mode == SPM_OPEN_WIN);
  wire fault = i_fault_external | i_fault_controller;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_switch_closed <= 1'b1;
      o_health_ok_output <= 1'b0;
      o_online <= 1'b0;
      o_activity_run <= 1'b0;
      o_message <= MSG_PROCESS;
    end else begin
      if (state != SPM_ONLINE) o_switch_closed <= !open_mode;
      else o_switch_closed <= open_mode ? !tripped : tripped;
      o_health_ok_output <= (state == SPM_ONLINE) && !fault;
      o_online <= (state == SPM_ONLINE);
      o_activity_run <= !i_fault_controller;
      unique case (state)
        SPM_ONLINE, SPM_ARMED: o_message <= i_fault_external ? MSG_ERROR : MSG_PROCESS;
        SPM_PASSWORD: o_message <= MSG_PASSWORD;
        SPM_PASS_OK: o_message <= MSG_OK;
        SPM_LATCH_PROMPT: o_message <= MSG_LATCH_PROMPT;
        SPM_LATCH_DONE: o_message <= MSG_LATCH_DONE;
        SPM_EXTREMES: o_message <= MSG_EXTREMES;
        SPM_UNITS: o_message <= MSG_UNITS;
        SPM_UNIT_SEL: o_message <= MSG_UNIT_SEL;
        SPM_SWITCH_MODE: o_message <= MSG_MODE;
        SPM_COMMIT: o_message <= MSG_COMMIT;
        SPM_COMMIT_SEL: o_message <= db_bad ? MSG_DEADBAND_BAD
          : (yes_sel ? MSG_COMMIT_YES : MSG_COMMIT_NO);
      endcase
    end
  end

  assign o_digit_index = {2'h0, digit};
  assign o_digit_value = pw_entry[digit*4 +: 4];
  assign o_unit = (state == SPM_UNIT_SEL) ? edit_unit : unit;
  assign o_unit_changed = unit_pulse;
  assign o_extremes_clear_cmd = clr_pulse;
  assign o_latched = latched;
  assign o_tripped = tripped;

  AST_HEALTH_OFF_FAULT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    fault |=> !o_health_ok_output)
    else $error("health output on during fault");
  AST_OFFLINE_HEALTH: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state != SPM_ONLINE) |=> !o_health_ok_output)
    else $error("health output on while programming");
  AST_FAILSAFE_OPEN: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == SPM_SWITCH_MODE && open_mode) |=> !o_switch_closed)
    else $error("open mode switch not open while programming");
  AST_TIMEOUT_EXIT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (timeout && state != SPM_ONLINE && state != SPM_ARMED) |=> state == SPM_ONLINE)
    else $error("timeout did not return online");
  sequence s_commit_confirm;
    state == SPM_COMMIT_SEL && key_bus.both_ev && !timeout && !yes_sel;
  endsequence
  AST_DISCARD: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_commit_confirm |=> state == SPM_ONLINE && $stable(mode) && $stable(db))
    else $error("discard changed stored parameters");
  AST_LATCH_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    latched |=> tripped)
    else $error("latched switch not tripped");
  AST_LATCH_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == SPM_LATCH_PROMPT && key_bus.both_ev && !timeout)
    |=> state == SPM_LATCH_DONE)
    else $error("latch release not confirmed");
  AST_DB_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    db != '0)
    else $error("zero deadband stored");
  AST_RISE_TRIP: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == SPM_ONLINE && mode == SPM_OPEN_RISE && i_process_value >= sp_hi)
    |=> tripped)
    else $error("rising mode did not trip");
endmodule // spm_top

// file: bench/spm_keypad_model.sv
// spm_keypad_model: operator keypad, presses keys when the bench asks
// assumes keys are active high; a press outlasts the block's debounce
`timescale 1ns/10ps
module spm_keypad_model #(
  parameter int HOLD = 6
) (
  // clock
  input wire logic i_ref_clk,
  // request: 1 left, 2 right, 3 both
  input wire logic i_req,
  input wire logic [1:0] i_code,
  // keys and completion
  output logic o_key_left,
  output logic o_key_right,
  output logic o_done
);
  // press, hold, release together, rest, then pulse done
  initial begin
    o_key_left = 1'b0;
    o_key_right = 1'b0;
    o_done = 1'b0;
    forever begin
      @(posedge i_ref_clk);
      if (i_req) begin
        #1;
        o_key_left = i_code[0];
        o_key_right = i_code[1];
        repeat (HOLD) @(posedge i_ref_clk);
        #1;
        o_key_left = 1'b0;
        o_key_right = 1'b0;
        repeat (HOLD) @(posedge i_ref_clk);
        #1 o_done = 1'b1;
        @(posedge i_ref_clk);
        #1 o_done = 1'b0;
      end
    end
  end
endmodule // spm_keypad_model

// file: bench/spm_top_bench.sv
// spm_top_bench: self-checking bench for the set point switch and menu block
// assumes the keypad model drives the keys and a 10 MHz clock
`timescale 1ns/10ps
module spm_top_bench import spm_pkg::*;;
  logic clk, rst, req, done, kl, kr, fx, fc, latch, t, uc, xc;
  logic closed, health, online, act, unit_chg, xclr, latched, tripped;
  logic [1:0] code;
  logic [2:0] mode, cur, unit;
  logic [3:0] msg, di, dv;
  logic signed [15:0] pv, hi, lo;
  logic [15:0] db;
  logic [31:0] seed;
  int bad_count, tests_run, sp, d, v, k, m, n;
  localparam logic [3:0] SEQ [4] = '{MSG_UNITS, MSG_MODE, MSG_COMMIT, MSG_EXTREMES};

  spm_top #(.PRESCALE(10), .TIMEOUT(8), .DEB_CYC(2)) u_spm_top (
    .i_ref_clk(clk), .i_srst(rst), .i_key_left(kl), .i_key_right(kr),
    .i_process_value(pv), .i_fault_external(fx), .i_fault_controller(fc),
    .i_edit_mode(mode), .i_edit_setpoint_hi(hi), .i_edit_setpoint_lo(lo),
    .i_edit_deadband(db), .i_edit_latch_en(latch), .o_switch_closed(closed),
    .o_health_ok_output(health), .o_online(online), .o_activity_run(act),
    .o_message(msg), .o_digit_index(di), .o_digit_value(dv), .o_unit(unit),
    .o_unit_changed(unit_chg), .o_extremes_clear_cmd(xclr), .o_latched(latched),
    .o_tripped(tripped));
  spm_keypad_model u_spm_keypad_model (
    .i_ref_clk(clk), .i_req(req), .i_code(code), .o_key_left(kl),
    .o_key_right(kr), .o_done(done));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // catch the one-cycle unit-change and extremes-clear pulses
  always @(posedge clk) begin
    if (rst) begin
      uc <= 1'b0;
      xc <= 1'b0;
    end else begin
      if (unit_chg === 1'b1) uc <= 1'b1;
      if (xclr === 1'b1) xc <= 1'b1;
    end
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed & 32'h3FF);
  endfunction

  // expected trip state after one process sample
  function automatic logic nxt(input logic t0, input int x);
    if (latch && t0) return 1'b1; // a latched trip ignores the process value
    case (cur % 3)
      0: nxt = x >= sp ? 1'b1 : (x <= sp - d ? 1'b0 : t0);
      1: nxt = x <= sp ? 1'b1 : (x >= sp + d ? 1'b0 : t0);
      default: nxt = x > hi || x < lo;
    endcase
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one key event through the keypad, then let the outputs settle
  task automatic key(input logic [1:0] c);
    @(posedge clk) #1;
    req = 1'b1;
    code = c;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 200);
    #1 req = 1'b0;
    if (n >= 200) begin
      bad_count++;
      results();
    end
    repeat (4) @(posedge clk);
  endtask

  // enter programming, password 0000 or 1000, step past OK
  task automatic prog(input logic bad);
    key(3);
    key(2);
    if (bad) key(1);
    if (bad) chk({di, dv}, 8'h01);
    repeat (4) key(2);
    if (!bad) chk(msg, MSG_OK);
    if (!bad) key(2);
  endtask

  task automatic commit(input logic yes);
    key(3);
    key(2);
    chk(msg, MSG_COMMIT_NO);
    if (yes) key(1);
    if (yes) chk(msg, MSG_COMMIT_YES);
    key(3);
  endtask

  task automatic apply(input int x);
    @(posedge clk) #1;
    pv = x[15:0];
    repeat (4) @(posedge clk);
    t = nxt(t, x);
    chk(tripped, t);
    chk(closed, cur >= 3 ? t : !t);
  endtask

  // main sequence
  initial begin
    {rst, req, code, fx, fc, latch, t, mode, cur} = 0;
    rst = 1'b1;
    {pv, hi, lo} = 0;
    db = 16'h0001;
    seed = 32'd20737;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    chk(closed, 1'b1);
    chk(health, 1'b0);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    chk(online, 1'b1);
    chk(health, 1'b1);
    chk(act, 1'b1);
    prog(1);
    chk(online, 1'b1);
    for (m = 0; m < 6; m++) begin
      sp = rnd() - 512;
      d = 1 + rnd() % 20;
      mode = m[2:0];
      hi = m % 3 == 2 ? sp + 2 * d + 1 : sp;
      lo = m % 3 == 2 ? sp - 1 : sp;
      db = d[15:0];
      prog(0);
      chk(online, 1'b0);
      chk(health, 1'b0);
      chk(closed, cur >= 3);
      commit(1);
      cur = mode;
      chk(online, 1'b1);
      for (k = 0; k < 8; k++) begin
        v = sp + 2 * ((rnd() % (2 * d + 8)) - d - 4);
        if (k < 4 && m % 3 != 2)
          v = k == 1 ? sp : sp - (m % 3 ? -1 : 1) * (d + (k == 0) - (k == 2));
        apply(v);
      end
    end
    // latch holds, then released from the menu
    {mode, sp, d, hi, lo, db, latch} = {3'h0, 32'd0, 32'd4, 16'h0, 16'h0, 16'h4, 1'b1};
    prog(0);
    commit(1);
    cur = 3'h0;
    apply(0);
    apply(-100);
    chk(tripped, 1'b1);
    chk(latched, 1'b1);
    prog(0);
    chk(msg, MSG_LATCH_PROMPT);
    key(3);
    chk(msg, MSG_LATCH_DONE);
    chk(latched, 1'b0);
    key(2);
    chk(online, 1'b1);
    chk(tripped, 1'b0);
    latch = 1'b0;
    // zero deadband refused, then idle timeout
    db = 16'h0000;
    prog(0);
    commit(1);
    chk(msg, MSG_DEADBAND_BAD);
    chk(online, 1'b0);
    n = 0;
    while (online !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk(online, 1'b1);
    if (n >= 600) results();
    // discard keeps the stored open mode
    {db, mode} = {16'h0004, 3'h3};
    prog(0);
    commit(0);
    chk(online, 1'b1);
    chk(msg, MSG_PROCESS);
    prog(0);
    chk(closed, 1'b0);
    for (k = 0; k < 4; k++) begin
      key(1);
      chk(msg, SEQ[k]);
    end
    key(1);
    key(2);
    chk(unit, UNIT_RST);
    key(1);
    chk(unit, 3'h1);
    key(2);
    chk(msg, MSG_UNITS);
    commit(1);
    chk({uc, xc, unit}, {2'b11, 3'h1});
    // faults
    @(posedge clk) #1 fx = 1'b1;
    repeat (4) @(posedge clk);
    chk(health, 1'b0);
    chk(msg, MSG_ERROR);
    #1 {fx, fc} = 2'b01;
    repeat (4) @(posedge clk);
    chk(act, 1'b0);
    chk(health, 1'b0);
    results();
  end
endmodule // spm_top_bench
